// [logic/pci_tgt_map.svh]
`ifndef PCI_TGT_MAP_SVH
`define PCI_TGT_MAP_SVH
// Behaviour
// RULE_01 - I/O space is reached only by 32-bit transfers, one data phase each.
// RULE_02 - Back-end decodes all 32 I/O address bits and chooses supported byte enables.
// RULE_03 - Back-end requests a target abort for unsupported I/O byte enables.
// RULE_04 - A party that signalled ready holds it until the data phase completes. Target ready drops early on a back-end abort.
// RULE_05 - Once target ready is asserted, no wait state until the next phase.
// RULE_06 - Data transfer is held while the master withholds initiator ready.
// RULE_07 - Target wait states are paced by the back-end ready input.
// RULE_08 - Slow select timing asserts device select one clock after region match.
// RULE_09 - Address and command decode starts the cycle after the address phase.
// RULE_10 - Target ready stays deasserted until the back-end has signalled ready.
// RULE_11 - Strobe asserts after a cycle with initiator ready and back-end ready.
// RULE_12 - Strobe deasserts after any cycle without initiator ready.
// RULE_13 - Read phase asserts target ready and drives back-end data on the bus.
// RULE_14 - Back-end ready held two cycles keeps target ready and next word going.
// RULE_15 - Back-end advances its address counter on each transfer strobe.
// RULE_16 - Master releases the bus in read turnaround, then asserts initiator ready.
// RULE_17 - Ready master keeps initiator ready and drives next byte enables.
// RULE_18 - Master marks the final phase by deasserting frame with initiator ready.
// RULE_19 - Turnaround after the final phase deasserts device select and target ready.
// RULE_20 - Idle cycle after that stops driving device select and target ready.
// RULE_21 - Completion clears the region match indication and the transfer strobe.
`define CMD_IO_READ 4'h2
`define CMD_IO_WRITE 4'h3
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_MEM_READ_MULT 4'hC
`define CMD_MEM_READ_LINE 4'hE
`define CMD_MEM_WRITE_INV 4'hF
`define BAR_MEM_BASE 32'h1000_0000
`define BAR_MEM_MASK 32'hFFFF_0000
`define BAR_IO_BASE 32'h0000_0300
`define BAR_IO_MASK 32'hFFFF_FFFF
`define HIT_MEM 0
`define HIT_IO 1
`define DATA_WIDTH 32
`define FIFO_DEPTH 32
`define DEVSEL_SLOW 1'b1
`endif

// [logic/pci_tgt_pkg.sv]
package pci_tgt_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_DECODE = 6'h02,
      ST_HIT = 6'h04,
      ST_DATA = 6'h08,
      ST_STOP = 6'h10,
      ST_TURN = 6'h20
   } tgt_state_t;
   typedef logic [3:0] pci_cmd_t;
endpackage

// [logic/tgt_fifo.sv]
`timescale 1ns/1ps
module tgt_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32,
   parameter int AW = $clog2(DEPTH)
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_flush,
   // Fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data,
   output logic [AW:0] o_level
);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic [WIDTH-1:0] dout_r;
   wire push = i_in_valid & o_in_ready;
   wire pop = i_out_ready & o_out_valid;
   wire [AW-1:0] rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
   wire bypass = push & (wr_ptr_r == rd_ptr_nxt);
   wire [AW:0] count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
   assign o_in_ready = count_r != FULL_CNT;
   assign o_out_valid = count_r != '0;
   assign o_out_data = dout_r;
   assign o_level = count_r;
   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem[wr_ptr_r] <= i_in_data;
      end
   end
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         dout_r <= '0;
      end else if (i_flush) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
         dout_r <= bypass ? i_in_data : mem[rd_ptr_nxt];
      end
   end
endmodule

// [logic/pci_target_wait_state_io.sv]
`timescale 1ns/1ps
`include "pci_tgt_map.svh"
module pci_target_wait_state_io #(
   parameter int DATA_W = `DATA_WIDTH,
   parameter int FIFO_DEPTH = `FIFO_DEPTH,
   parameter logic DEVSEL_SLOW = `DEVSEL_SLOW,
   parameter logic [31:0] MEM_BASE = `BAR_MEM_BASE,
   parameter logic [31:0] MEM_MASK = `BAR_MEM_MASK,
   parameter logic [31:0] IO_BASE = `BAR_IO_BASE,
   parameter logic [31:0] IO_MASK = `BAR_IO_MASK
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // PCI bus
   input wire logic i_frame_n,
   input wire logic i_irdy_n,
   input wire logic [DATA_W-1:0] i_ad,
   input wire logic [3:0] i_cbe_n,
   output logic [DATA_W-1:0] o_ad,
   output logic o_ad_oe_n,
   output logic o_devsel_n,
   output logic o_devsel_oe_n,
   output logic o_trdy_n,
   output logic o_trdy_oe_n,
   output logic o_stop_n,
   output logic o_stop_oe_n,
   // Local target interface
   input wire logic i_backend_ready_n,
   input wire logic i_backend_abort_n,
   input wire logic [DATA_W-1:0] i_lt_data_in,
   output logic o_local_transfer_strobe_n,
   output logic [1:0] o_bar_hit,
   output logic [31:0] o_lt_address,
   output pci_tgt_pkg::pci_cmd_t o_lt_command,
   output logic [3:0] o_lt_cbe_n,
   output logic o_lt_r_nw,
   output logic [DATA_W-1:0] o_lt_data_out
);
   import pci_tgt_pkg::*;

   localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;
   localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(FIFO_DEPTH);

   tgt_state_t state_r;
   tgt_state_t state_nxt;
   logic frame_prev_r;
   logic [31:0] addr_r;
   pci_cmd_t cmd_r;
   logic is_read_r;
   logic is_io_r;
   logic io_word_r;
   logic abort_r;
   logic devsel_r;
   logic trdy_r;
   logic stop_r;
   logic ctl_drive_r;
   logic ad_drive_r;
   logic [1:0] bar_hit_r;
   logic strobe_r;
   logic [3:0] cbe_r;
   logic [DATA_W-1:0] wdata_r;
   logic [DATA_W-1:0] fifo_dout;
   logic fifo_out_valid;
   logic fifo_in_ready;
   logic [LVL_W-1:0] fifo_level;

   // Address phase capture and command decode
   wire addr_phase = (state_r == ST_IDLE) & ~i_frame_n & frame_prev_r;
   wire cmd_io_rd = cmd_r == `CMD_IO_READ;
   wire cmd_io_wr = cmd_r == `CMD_IO_WRITE;
   wire cmd_mem_rd = (cmd_r == `CMD_MEM_READ) | (cmd_r == `CMD_MEM_READ_MULT) | (cmd_r == `CMD_MEM_READ_LINE);
   wire cmd_mem_wr = (cmd_r == `CMD_MEM_WRITE) | (cmd_r == `CMD_MEM_WRITE_INV);
   wire hit_mem = (cmd_mem_rd | cmd_mem_wr) & ((addr_r & MEM_MASK) == MEM_BASE);
   wire hit_io = (cmd_io_rd | cmd_io_wr) & ((addr_r & IO_MASK) == IO_BASE);
   wire any_hit = hit_mem | hit_io;
   wire cmd_is_read = cmd_mem_rd | cmd_io_rd;
   wire cmd_is_io = cmd_io_rd | cmd_io_wr;

   // Data phase events
   wire in_active = (state_r == ST_HIT) | (state_r == ST_DATA);
   wire phase_done = (state_r == ST_DATA) & trdy_r & ~i_irdy_n;
   wire last_done = phase_done & i_frame_n;
   wire io_done = phase_done & is_io_r;
   wire abort_evt = in_active & ~i_backend_abort_n;
   wire stop_exit = (state_r == ST_STOP) & i_frame_n & ~i_irdy_n;

   // FIFO traffic
   wire fifo_push = ~strobe_r & is_read_r & fifo_in_ready;
   wire fifo_pop = phase_done & is_read_r & fifo_out_valid;
   wire [LVL_W-1:0] level_nxt = fifo_level + LVL_W'(fifo_push) - LVL_W'(fifo_pop);
   wire room_nxt = level_nxt < FULL_LVL;
   wire io_gate = ~(is_io_r & io_word_r);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (addr_phase) begin
               state_nxt = ST_DECODE;
            end
         end
         ST_DECODE: begin
            state_nxt = any_hit ? ST_HIT : ST_IDLE; // [RULE_09]
         end
         ST_HIT: begin
            state_nxt = abort_evt ? ST_STOP : ST_DATA;
         end
         ST_DATA: begin
            if (abort_evt) begin
               state_nxt = ST_STOP; // [RULE_03]
            end else if (last_done) begin
               state_nxt = ST_TURN; // [RULE_19]
            end else if (io_done) begin
               state_nxt = ST_STOP; // [RULE_01]
            end
         end
         ST_STOP: begin
            if (stop_exit) begin
               state_nxt = ST_TURN;
            end
         end
         ST_TURN: begin
            state_nxt = ST_IDLE; // [RULE_20]
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Transfer strobe to the back-end
   wire strobe_ok = in_active & ~abort_evt & ~last_done & ~io_done;
   wire rd_strobe = is_read_r & room_nxt & io_gate;
   wire wr_strobe = ~is_read_r & trdy_r;
   wire strobe_nxt = strobe_ok & ~i_irdy_n & ~i_backend_ready_n & (rd_strobe | wr_strobe); // [RULE_11] [RULE_12]

   // Target ready: held until phase end or back-end abort, otherwise paced by the back-end
   wire trdy_hold = trdy_r & ~phase_done; // [RULE_04] [RULE_05] [RULE_06]
   wire trdy_end = last_done | io_done | abort_evt;
   wire rd_avail = level_nxt != '0; // [RULE_13] [RULE_14]
   wire wr_avail = ~i_backend_ready_n & ~(is_io_r & io_word_r);
   wire trdy_new = in_active & (is_read_r ? rd_avail : wr_avail); // [RULE_07] [RULE_10]
   wire trdy_nxt = ~trdy_end & (trdy_hold | trdy_new);

   // Device select, stop and drive enables follow the next state
   wire abort_nxt = abort_evt | (abort_r & (state_r != ST_TURN));
   wire devsel_nxt = ((state_nxt == ST_HIT) & ~DEVSEL_SLOW) | (state_nxt == ST_DATA) |
                     ((state_nxt == ST_STOP) & ~abort_nxt); // [RULE_08] [RULE_19]
   wire stop_nxt = (state_nxt == ST_STOP) | ((state_nxt == ST_DATA) & trdy_nxt & is_io_r); // [RULE_01]
   wire ctl_drive_nxt = (state_nxt == ST_HIT) | (state_nxt == ST_DATA) | (state_nxt == ST_STOP) |
                        (state_nxt == ST_TURN); // [RULE_20]
   wire ad_drive_nxt = (state_nxt == ST_DATA) & is_read_r; // [RULE_13]
   wire io_word_nxt = ~addr_phase & (io_word_r | strobe_nxt | (phase_done & is_io_r));

   // Region match indication
   wire [1:0] hit_vec = {hit_io, hit_mem};
   wire [1:0] bar_hit_nxt = (state_r == ST_DECODE) ? hit_vec :
                            (state_r == ST_TURN) ? 2'h0 : bar_hit_r; // [RULE_21]

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
         frame_prev_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         frame_prev_r <= i_frame_n;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         addr_r <= 32'h0000_0000;
         cmd_r <= 4'h0;
         is_read_r <= 1'b0;
         is_io_r <= 1'b0;
      end else if (addr_phase) begin
         addr_r <= i_ad[31:0];
         cmd_r <= i_cbe_n;
      end else if (state_r == ST_DECODE) begin
         is_read_r <= cmd_is_read;
         is_io_r <= cmd_is_io;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         devsel_r <= 1'b0;
         trdy_r <= 1'b0;
         stop_r <= 1'b0;
         ctl_drive_r <= 1'b0;
         ad_drive_r <= 1'b0;
         abort_r <= 1'b0;
         io_word_r <= 1'b0;
      end else begin
         devsel_r <= devsel_nxt;
         trdy_r <= trdy_nxt;
         stop_r <= stop_nxt;
         ctl_drive_r <= ctl_drive_nxt;
         ad_drive_r <= ad_drive_nxt;
         abort_r <= abort_nxt;
         io_word_r <= io_word_nxt;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         bar_hit_r <= 2'h0;
         strobe_r <= 1'b1;
         cbe_r <= 4'hF;
         wdata_r <= '0;
      end else begin
         bar_hit_r <= bar_hit_nxt;
         strobe_r <= ~strobe_nxt; // [RULE_21]
         cbe_r <= in_active ? i_cbe_n : cbe_r;
         wdata_r <= (phase_done & ~is_read_r) ? i_ad : wdata_r;
      end
   end

   // Read words from the back-end, one per strobe
   tgt_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rd_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_flush(state_r == ST_TURN),
      .i_in_valid(fifo_push),
      .o_in_ready(fifo_in_ready),
      .i_in_data(i_lt_data_in),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_dout),
      .o_level(fifo_level)
   );

   assign o_ad = fifo_dout;
   assign o_ad_oe_n = ~ad_drive_r;
   assign o_devsel_n = ~devsel_r;
   assign o_devsel_oe_n = ~ctl_drive_r;
   assign o_trdy_n = ~trdy_r;
   assign o_trdy_oe_n = ~ctl_drive_r;
   assign o_stop_n = ~stop_r;
   assign o_stop_oe_n = ~ctl_drive_r;
   assign o_local_transfer_strobe_n = strobe_r;
   assign o_bar_hit = bar_hit_r;
   assign o_lt_address = addr_r;
   assign o_lt_command = cmd_r;
   assign o_lt_cbe_n = cbe_r;
   assign o_lt_r_nw = is_read_r;
   assign o_lt_data_out = wdata_r;
endmodule

// [dv/pci_tgt_checker.sv]
`timescale 1ns/1ps
module pci_tgt_checker (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Watched ports
   input wire logic i_frame_n,
   input wire logic i_irdy_n,
   input wire logic i_backend_ready_n,
   input wire logic o_ad_oe_n,
   input wire logic o_devsel_n,
   input wire logic o_devsel_oe_n,
   input wire logic o_trdy_n,
   input wire logic o_trdy_oe_n,
   input wire logic o_stop_n,
   input wire logic o_stop_oe_n,
   input wire logic o_local_transfer_strobe_n,
   input wire logic [1:0] o_bar_hit,
   input wire logic o_lt_r_nw
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   // Final data phase completing
   sequence last_done;
      !i_irdy_n && !o_trdy_n && i_frame_n;
   endsequence
   AST_DEVSEL: assert property ($rose(|o_bar_hit) |=> $fell(o_devsel_n))
      else $error("devsel not one clock after region match");
   AST_DECODE: assert property ($rose(|o_bar_hit) |-> !$past(i_frame_n, 2) && $past(i_frame_n, 3))
      else $error("region match not two clocks after address phase");
   AST_TRDY_HOLD: assert property (!o_trdy_n && i_irdy_n |=> !o_trdy_n)
      else $error("target ready dropped before phase end");
   AST_TRDY_WAIT: assert property ($fell(o_trdy_n) |-> !$past(i_backend_ready_n) || !$past(i_backend_ready_n, 2))
      else $error("target ready without back-end ready");
   AST_STROBE_IDLE: assert property (i_irdy_n |=> o_local_transfer_strobe_n)
      else $error("strobe after cycle without initiator ready");
   AST_STROBE_CAUSE: assert property (!o_local_transfer_strobe_n |-> !$past(i_irdy_n) && !$past(i_backend_ready_n))
      else $error("strobe without initiator and back-end ready before");
   AST_AD_DRIVE: assert property (!o_trdy_n && o_lt_r_nw |-> !o_ad_oe_n)
      else $error("read data phase without bus drive");
   AST_IO_STOP: assert property (!o_trdy_n && o_bar_hit[1] |-> !o_stop_n)
      else $error("I/O phase without disconnect");
   AST_TURN: assert property (last_done |=> o_devsel_n && o_trdy_n)
      else $error("select or ready kept in turnaround");
   AST_RELEASE: assert property (last_done |-> ##2 (o_devsel_oe_n && o_trdy_oe_n && o_stop_oe_n))
      else $error("pins still driven in idle");
   AST_DONE_LOCAL: assert property (last_done |-> ##2 (o_bar_hit == 2'b00 && o_local_transfer_strobe_n))
      else $error("completion not shown to back-end");
endmodule
bind pci_target_wait_state_io pci_tgt_checker chk_u (.i_clk_sys, .i_rst, .i_frame_n, .i_irdy_n,
   .i_backend_ready_n, .o_ad_oe_n, .o_devsel_n, .o_devsel_oe_n, .o_trdy_n, .o_trdy_oe_n, .o_stop_n,
   .o_stop_oe_n, .o_local_transfer_strobe_n, .o_bar_hit, .o_lt_r_nw);

// [dv/backend_model.sv]
`timescale 1ns/1ps
module backend_model (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Bench control
   input wire logic [3:0] i_delay,
   input wire logic i_abort,
   // Local target interface
   input wire logic i_strobe_n,
   input wire logic [1:0] i_bar_hit,
   output logic o_ready_n,
   output logic o_abort_n,
   output logic [31:0] o_data
);
   logic [3:0] wait_r;
   logic [31:0] count_r;
   logic abort_r;
   wire logic active = |i_bar_hit;
   wire logic [31:0] word = 32'hA5A5_0000 + count_r;
   assign o_ready_n = !(active && wait_r >= i_delay);
   assign o_abort_n = abort_r;
   assign o_data = i_strobe_n ? ~word : word;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         wait_r <= 4'h0;
         count_r <= 32'h0;
         abort_r <= 1'b1;
      end else begin
         wait_r <= !active ? 4'h0 : (wait_r == 4'hF ? wait_r : wait_r + 4'h1);
         count_r <= !active ? 32'h0 : count_r + {31'h0, !i_strobe_n};
         abort_r <= !(i_abort && active);
      end
   end
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
`include "pci_tgt_map.svh"
module tb;
   logic clk, rst, frame_n, irdy_n, abrt;
   logic [31:0] ad, ad_o, lt_addr, lt_din, lt_dout;
   logic [3:0] cbe_n, dly, lt_cbe, lt_cmd;
   logic ad_oe_n, devsel_n, devsel_oe_n, trdy_n, trdy_oe_n, stop_n, stop_oe_n, strobe_n, rdy_n, abt_n, r_nw;
   logic [1:0] bar_hit;
   int miscompares = 0;
   int checks_done = 0;
   pci_target_wait_state_io dut_u (.i_clk_sys(clk), .i_rst(rst), .i_frame_n(frame_n), .i_irdy_n(irdy_n),
      .i_ad(ad), .i_cbe_n(cbe_n), .o_ad(ad_o), .o_ad_oe_n(ad_oe_n), .o_devsel_n(devsel_n),
      .o_devsel_oe_n(devsel_oe_n), .o_trdy_n(trdy_n), .o_trdy_oe_n(trdy_oe_n), .o_stop_n(stop_n),
      .o_stop_oe_n(stop_oe_n), .i_backend_ready_n(rdy_n), .i_backend_abort_n(abt_n), .i_lt_data_in(lt_din),
      .o_local_transfer_strobe_n(strobe_n), .o_bar_hit(bar_hit), .o_lt_address(lt_addr),
      .o_lt_command(lt_cmd), .o_lt_cbe_n(lt_cbe), .o_lt_r_nw(r_nw), .o_lt_data_out(lt_dout));
   backend_model be_u (.i_clk_sys(clk), .i_rst(rst), .i_delay(dly), .i_abort(abrt), .i_strobe_n(strobe_n),
      .i_bar_hit(bar_hit), .o_ready_n(rdy_n), .o_abort_n(abt_n), .o_data(lt_din));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Read of n phases, optional master wait after the first phase
   task automatic rd(input logic [31:0] a, input logic [3:0] c, input int n, input logic w, input logic [3:0] d);
      int k;
      int t;
      logic hit;
      dly = d;
      @(negedge clk);
      frame_n = 1'b0;
      ad = a;
      cbe_n = c;
      @(negedge clk);
      ad = ~a;
      cbe_n = 4'h0;
      irdy_n = 1'b0;
      frame_n = n == 1;
      k = 0;
      t = 0;
      hit = 1'b0;
      while (k < n && t < 80) begin
         @(negedge clk);
         t++;
         if (hit) begin
            k++;
            irdy_n = (w && k == 1) || k == n;
            frame_n = k >= n - 1;
         end else if (irdy_n) begin
            irdy_n = 1'b0;
         end
         hit = k < n && !irdy_n && trdy_n === 1'b0;
         if (hit) begin
            chk("read word", ad_o, 32'hA5A5_0000 + k);
            chk("stop", stop_n, c != `CMD_IO_READ);
         end
      end
      chk("phases", k, n);
      chk("address", lt_addr, a);
      chk("command", lt_cmd, c);
      chk("direction", r_nw, 1'b1);
      chk("byte enables", lt_cbe, 4'h0);
      chk("turn", {devsel_n, trdy_n}, 2'b11);
      @(negedge clk);
      chk("release", {devsel_oe_n, trdy_oe_n, ad_oe_n}, 3'b111);
      chk("done", {bar_hit, strobe_n}, 3'b001);
   endtask
   // Single-phase memory write, back-end ready at once
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      int t;
      dly = 4'h0;
      @(negedge clk);
      frame_n = 1'b0;
      ad = a;
      cbe_n = `CMD_MEM_WRITE;
      @(negedge clk);
      ad = v;
      cbe_n = 4'h0;
      irdy_n = 1'b0;
      frame_n = 1'b1;
      t = 0;
      while (trdy_n !== 1'b0 && t < 20) begin
         @(negedge clk);
         t++;
      end
      @(negedge clk);
      irdy_n = 1'b1;
      chk("write word", lt_dout, v);
      chk("write direction", r_nw, 1'b0);
      chk("write turn", {devsel_n, trdy_n}, 2'b11);
      @(negedge clk);
      chk("write release", {devsel_oe_n, trdy_oe_n, bar_hit}, 4'b1100);
   endtask
   // I/O read refused by the back-end
   task automatic abort_io;
      int t;
      dly = 4'hF;
      abrt = 1'b1;
      @(negedge clk);
      frame_n = 1'b0;
      ad = `BAR_IO_BASE;
      cbe_n = `CMD_IO_READ;
      @(negedge clk);
      ad = 32'h0;
      cbe_n = 4'hA;
      irdy_n = 1'b0;
      frame_n = 1'b1;
      t = 0;
      while (stop_n !== 1'b0 && t < 20) begin
         @(negedge clk);
         t++;
      end
      chk("abort", {stop_n, devsel_n, trdy_n}, 3'b011);
      chk("abort enables", lt_cbe, 4'hA);
      @(negedge clk);
      irdy_n = 1'b1;
      abrt = 1'b0;
      repeat (3) @(negedge clk);
      chk("abort end", {bar_hit, stop_oe_n}, 3'b001);
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #20000;
      miscompares++;
      report_and_stop;
   end
   initial begin
      rst = 1'b1;
      frame_n = 1'b1;
      irdy_n = 1'b1;
      ad = 32'h0;
      cbe_n = 4'hF;
      dly = 4'h0;
      abrt = 1'b0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rd(`BAR_MEM_BASE, `CMD_MEM_READ, 1, 1'b0, 4'h3);
      rd(`BAR_MEM_BASE + 32'h40, `CMD_MEM_READ_MULT, 3, 1'b1, 4'h0);
      rd(`BAR_MEM_BASE + 32'h80, `CMD_MEM_READ_LINE, 5, 1'b0, 4'h1);
      rd(`BAR_IO_BASE, `CMD_IO_READ, 1, 1'b0, 4'h2);
      wr(`BAR_MEM_BASE + 32'hC0, 32'h5A5A_0001);
      abort_io;
      report_and_stop;
   end
endmodule
